// file: inc/lhs_pkg.sv
package lhs_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_CH1_WIDTH_LOW  = 8'h28;
	localparam logic [7:0] ADDR_CH1_WIDTH_HIGH = 8'h29;
	localparam logic [7:0] ADDR_CH2_WIDTH_LOW  = 8'h2a;
	localparam logic [7:0] ADDR_CH2_WIDTH_HIGH = 8'h2b;
	localparam logic [7:0] ADDR_CH1_ON_TIME    = 8'h2c;
	localparam logic [7:0] ADDR_CH2_ON_TIME    = 8'h2d;
	localparam logic [7:0] ADDR_SOFT_RESET     = 8'h2e;

	// ****************************************
	// field layout, reset values and key codes
	// ****************************************
	localparam int         WIDTH_BITS       = 10;
	localparam int         ON_TIME_BITS     = 6;
	localparam int         WIDTH_HIGH_BITS  = 2;
	localparam logic [9:0] RST_DIM_WIDTH    = 10'h000;
	localparam logic [5:0] RST_ON_TIME      = 6'h07;
	localparam logic       RST_WDOG_ENABLE  = 1'b1;
	localparam logic [7:0] KEY_WDOG_OFF     = 8'hc3;
	localparam logic [7:0] KEY_WDOG_ON      = 8'hd4;
	localparam logic [7:0] READ_ZERO        = 8'h00;

	// fallback setpoints of both channels
	typedef struct packed {
		logic [9:0] fallback_ch1_dim_width;
		logic [9:0] fallback_ch2_dim_width;
		logic [5:0] fallback_ch1_on_time;
		logic [5:0] fallback_ch2_on_time;
	} lhs_setpoints_t;

	// commands to the channel-enable state machines
	typedef struct packed {
		logic force_load;
		logic force_detect;
	} lhs_chan_cmd_t;

	// command decode states, one-hot
	typedef enum logic [2:0] {
		CMD_IDLE   = 3'b001,
		CMD_OFF    = 3'b010,
		CMD_ON     = 3'b100
	} lhs_cmd_state_t;

endpackage

// file: verilog/lhs_regs.sv
`timescale 1ns/1ns
module lhs_regs
	import lhs_pkg::*;
(
	// clock and power-on reset
	input  wire logic           core_clk,
	input  wire logic           srst,
	// register access from the serial control port
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	input  wire logic [7:0]     reg_addr,
	input  wire logic [7:0]     reg_wdata,
	output logic      [7:0]     reg_rdata,
	output logic                reg_rvalid,
	// device context
	input  wire logic           stand_alone,
	input  wire logic           comm_watchdog_timeout_bits,
	input  wire logic           power_on_clear,
	// results
	output lhs_setpoints_t      setpoints,
	output logic                soft_reset_pulse,
	output logic                wdog_enable,
	output lhs_chan_cmd_t       chan_cmd,
	output logic                power_on_indicator_bit
);

	// ****************************************
	// command decode
	// ****************************************

	lhs_cmd_state_t cmd_state;
	lhs_cmd_state_t next_cmd_state;
	logic           cmd_wr;

	assign cmd_wr = reg_wr && (reg_addr == ADDR_SOFT_RESET);

	// classify a command write; other values stay idle
	always_comb
	begin
		next_cmd_state = CMD_IDLE;
		if (cmd_wr && reg_wdata == KEY_WDOG_OFF)
			next_cmd_state = CMD_OFF;
		else if (cmd_wr && reg_wdata == KEY_WDOG_ON)
			next_cmd_state = CMD_ON;
	end

	// soft reset pulse follows a key write by one cycle
	always_ff @(posedge core_clk)
	begin
		if (srst)
			cmd_state <= CMD_IDLE;
		else
			cmd_state <= next_cmd_state;
	end

	logic key_hit;
	assign key_hit = (next_cmd_state != CMD_IDLE);

	// ****************************************
	// writable setpoint registers
	// ****************************************

	// each byte lane written alone; key write restores defaults
	always_ff @(posedge core_clk)
	begin
		if (srst || key_hit)
		begin
			setpoints.fallback_ch1_dim_width <= RST_DIM_WIDTH;
			setpoints.fallback_ch2_dim_width <= RST_DIM_WIDTH;
			setpoints.fallback_ch1_on_time   <= RST_ON_TIME;
			setpoints.fallback_ch2_on_time   <= RST_ON_TIME;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				ADDR_CH1_WIDTH_LOW:
					setpoints.fallback_ch1_dim_width[7:0] <= reg_wdata;
				ADDR_CH1_WIDTH_HIGH:
					setpoints.fallback_ch1_dim_width[9:8] <= reg_wdata[1:0];
				ADDR_CH2_WIDTH_LOW:
					setpoints.fallback_ch2_dim_width[7:0] <= reg_wdata;
				ADDR_CH2_WIDTH_HIGH:
					setpoints.fallback_ch2_dim_width[9:8] <= reg_wdata[1:0];
				ADDR_CH1_ON_TIME:
					setpoints.fallback_ch1_on_time <= reg_wdata[5:0];
				ADDR_CH2_ON_TIME:
					setpoints.fallback_ch2_on_time <= reg_wdata[5:0];
				default:
					;
			endcase
		end
	end

	// ****************************************
	// watchdog enable and channel commands
	// ****************************************

	// watchdog follows the key used
	always_ff @(posedge core_clk)
	begin
		if (srst)
			wdog_enable <= RST_WDOG_ENABLE;
		else if (next_cmd_state == CMD_OFF)
			wdog_enable <= 1'b0;
		else if (next_cmd_state == CMD_ON)
			wdog_enable <= 1'b1;
	end

	// soft reset pulse is the registered command state itself
	assign soft_reset_pulse = (cmd_state != CMD_IDLE);

	// one-cycle pulses to the rest of the device
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			chan_cmd            <= '0;
		end
		else
		begin
			chan_cmd.force_load   <= stand_alone && next_cmd_state == CMD_OFF;
			chan_cmd.force_detect <= stand_alone && next_cmd_state == CMD_ON
				&& !comm_watchdog_timeout_bits;
		end
	end

	// ****************************************
	// power-on indicator
	// ****************************************

	// set only by power-on reset, cleared when status is read
	always_ff @(posedge core_clk)
	begin
		if (srst)
			power_on_indicator_bit <= 1'b1;
		else if (power_on_clear)
			power_on_indicator_bit <= 1'b0;
	end

	// ****************************************
	// read path
	// ****************************************

	// read data registered one cycle after the request
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			reg_rdata  <= READ_ZERO;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
			begin
				unique case (reg_addr)
					ADDR_CH1_WIDTH_LOW:
						reg_rdata <= setpoints.fallback_ch1_dim_width[7:0];
					ADDR_CH1_WIDTH_HIGH:
						reg_rdata <= {6'h00, setpoints.fallback_ch1_dim_width[9:8]};
					ADDR_CH2_WIDTH_LOW:
						reg_rdata <= setpoints.fallback_ch2_dim_width[7:0];
					ADDR_CH2_WIDTH_HIGH:
						reg_rdata <= {6'h00, setpoints.fallback_ch2_dim_width[9:8]};
					ADDR_CH1_ON_TIME:
						reg_rdata <= {2'h0, setpoints.fallback_ch1_on_time};
					ADDR_CH2_ON_TIME:
						reg_rdata <= {2'h0, setpoints.fallback_ch2_on_time};
					default:
						reg_rdata <= READ_ZERO;
				endcase
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	a_width_low_write: assert property (
		reg_wr && reg_addr == ADDR_CH1_WIDTH_LOW && !key_hit
		|=> setpoints.fallback_ch1_dim_width[7:0] == $past(reg_wdata))
		else $error("channel one width low byte not stored");

	a_width1_high_write: assert property (
		reg_wr && reg_addr == ADDR_CH1_WIDTH_HIGH
		|=> setpoints.fallback_ch1_dim_width[9:8] == $past(reg_wdata[1:0]))
		else $error("channel one width high bits not stored");

	a_width2_low_write: assert property (
		reg_wr && reg_addr == ADDR_CH2_WIDTH_LOW
		|=> setpoints.fallback_ch2_dim_width[7:0] == $past(reg_wdata))
		else $error("channel two width low byte not stored");

	a_width_high_write: assert property (
		reg_wr && reg_addr == ADDR_CH2_WIDTH_HIGH
		|=> setpoints.fallback_ch2_dim_width[9:8] == $past(reg_wdata[1:0]))
		else $error("channel two width high bits not stored");

	a_high_reserved_zero: assert property (
		reg_rd && (reg_addr == ADDR_CH1_WIDTH_HIGH || reg_addr == ADDR_CH2_WIDTH_HIGH)
		|=> reg_rvalid && reg_rdata[7:2] == 6'h00)
		else $error("reserved width bits not zero");

	a_on_time_read: assert property (
		reg_rd && reg_addr == ADDR_CH1_ON_TIME && !reg_wr
		|=> reg_rdata == {2'h0, $past(setpoints.fallback_ch1_on_time)})
		else $error("channel one on-time read wrong");

	a_on_time1_write: assert property (
		reg_wr && reg_addr == ADDR_CH1_ON_TIME
		|=> setpoints.fallback_ch1_on_time == $past(reg_wdata[5:0]))
		else $error("channel one on-time not stored");

	a_on_time2_write: assert property (
		reg_wr && reg_addr == ADDR_CH2_ON_TIME
		|=> setpoints.fallback_ch2_on_time == $past(reg_wdata[5:0]))
		else $error("channel two on-time not stored");

	a_on_time2_read: assert property (
		reg_rd && reg_addr == ADDR_CH2_ON_TIME && !reg_wr
		|=> reg_rdata == {2'h0, $past(setpoints.fallback_ch2_on_time)})
		else $error("channel two on-time read wrong");

	a_on_time_default: assert property (
		$rose(soft_reset_pulse) |-> setpoints.fallback_ch2_on_time == RST_ON_TIME
		&& setpoints.fallback_ch1_on_time == RST_ON_TIME)
		else $error("on-time not restored to default");

	a_key_restores_all: assert property (
		key_hit
		|=> setpoints == {RST_DIM_WIDTH, RST_DIM_WIDTH, RST_ON_TIME, RST_ON_TIME})
		else $error("key write left a setpoint off its default");

	a_key_off_effect: assert property (
		cmd_wr && reg_wdata == KEY_WDOG_OFF
		|=> !wdog_enable && soft_reset_pulse && setpoints.fallback_ch1_dim_width == RST_DIM_WIDTH)
		else $error("0xc3 did not restore and disable watchdog");

	a_wdog_stays_off: assert property (
		!wdog_enable && next_cmd_state != CMD_ON |=> !wdog_enable)
		else $error("watchdog came back without its key");

	a_force_load: assert property (
		cmd_wr && reg_wdata == KEY_WDOG_OFF && stand_alone
		|=> chan_cmd.force_load ##1 (!chan_cmd.force_load
		|| $past(cmd_wr && reg_wdata == KEY_WDOG_OFF && stand_alone)))
		else $error("load force missing or too long");

	a_load_has_cause: assert property (
		chan_cmd.force_load
		|-> $past(stand_alone) && $past(cmd_wr) && $past(reg_wdata) == KEY_WDOG_OFF)
		else $error("load force without its cause");

	a_key_on_effect: assert property (
		cmd_wr && reg_wdata == KEY_WDOG_ON
		|=> wdog_enable && soft_reset_pulse && setpoints.fallback_ch2_dim_width == RST_DIM_WIDTH)
		else $error("0xd4 did not restore or enable watchdog");

	a_force_detect: assert property (
		chan_cmd.force_detect |-> $past(stand_alone) && !$past(comm_watchdog_timeout_bits)
		&& $past(cmd_wr) && $past(reg_wdata) == KEY_WDOG_ON)
		else $error("detect force without its cause");

	a_detect_held_back: assert property (
		cmd_wr && reg_wdata == KEY_WDOG_ON && comm_watchdog_timeout_bits
		|=> !chan_cmd.force_detect && wdog_enable)
		else $error("detect forced while timeout bits still set");

	a_cmd_reads_zero: assert property (
		reg_rd && reg_addr == ADDR_SOFT_RESET |=> reg_rdata == READ_ZERO)
		else $error("command register read not zero");

	a_unmapped_reads_zero: assert property (
		reg_rd && (reg_addr < ADDR_CH1_WIDTH_LOW || reg_addr > ADDR_SOFT_RESET)
		|=> reg_rdata == READ_ZERO)
		else $error("unmapped offset read not zero");

	a_read_answer: assert property (
		reg_rd |=> reg_rvalid)
		else $error("read got no valid answer");

	a_read_pulse: assert property (
		!reg_rd |=> !reg_rvalid)
		else $error("read valid without a read");

	a_power_on_kept: assert property (
		soft_reset_pulse && !$past(power_on_clear)
		|-> power_on_indicator_bit == $past(power_on_indicator_bit))
		else $error("soft reset touched power-on indicator");

	a_power_on_restored: assert property (
		$past(srst) |-> power_on_indicator_bit)
		else $error("power-on reset did not set the indicator");

	a_other_code_inert: assert property (
		cmd_wr && reg_wdata != KEY_WDOG_OFF && reg_wdata != KEY_WDOG_ON
		|=> !soft_reset_pulse && $stable(wdog_enable) && $stable(setpoints))
		else $error("non-key command had an effect");

	c_key_off_alone: cover property (
		cmd_wr && reg_wdata == KEY_WDOG_OFF && stand_alone ##1 chan_cmd.force_load);
	c_key_on_alone: cover property (
		cmd_wr && reg_wdata == KEY_WDOG_ON ##1 chan_cmd.force_detect);
	c_width_roundtrip: cover property (
		reg_wr && reg_addr == ADDR_CH1_WIDTH_HIGH ##1 reg_rd && reg_addr == ADDR_CH1_WIDTH_HIGH);
	c_watchdog_back_on: cover property (
		!wdog_enable ##[1:20] wdog_enable);
	c_other_code_ignored: cover property (
		cmd_wr && reg_wdata == 8'h55);

endmodule

// file: verification/lhs_regs_tb.sv
`timescale 1ns/1ns
// compare one value with its expectation and count the result
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module lhs_regs_tb
	import lhs_pkg::*;
;
	// ****************************************
	// signals
	// ****************************************
	logic           core_clk;
	logic           srst;
	logic           reg_wr;
	logic           reg_rd;
	logic [7:0]     reg_addr;
	logic [7:0]     reg_wdata;
	logic [7:0]     reg_rdata;
	logic           reg_rvalid;
	logic           stand_alone;
	logic           comm_watchdog_timeout_bits;
	logic           power_on_clear;
	lhs_setpoints_t setpoints;
	logic           soft_reset_pulse;
	logic           wdog_enable;
	lhs_chan_cmd_t  chan_cmd;
	logic           power_on_indicator_bit;
	logic [7:0]     rd_val;
	int             bad_count;
	int             check_count;
	lhs_setpoints_t dflt;

	// rows: offset, write data, expected read back
	localparam logic [23:0] ROWS [8] = '{24'h28a5a5, 24'h29ff03, 24'h2a5a5a, 24'h2bfe02,
		24'h2cff3f, 24'h2dc808, 24'h2e5500, 24'h307700};

	// ****************************************
	// design and clock
	// ****************************************
	lhs_regs lhs_regs_inst (
		.core_clk                   (core_clk),
		.srst                       (srst),
		.reg_wr                     (reg_wr),
		.reg_rd                     (reg_rd),
		.reg_addr                   (reg_addr),
		.reg_wdata                  (reg_wdata),
		.reg_rdata                  (reg_rdata),
		.reg_rvalid                 (reg_rvalid),
		.stand_alone                (stand_alone),
		.comm_watchdog_timeout_bits (comm_watchdog_timeout_bits),
		.power_on_clear             (power_on_clear),
		.setpoints                  (setpoints),
		.soft_reset_pulse           (soft_reset_pulse),
		.wdog_enable                (wdog_enable),
		.chan_cmd                   (chan_cmd),
		.power_on_indicator_bit     (power_on_indicator_bit)
	);

	// 50 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// ****************************************
	// tasks
	// ****************************************
	// print counts and verdict, then stop
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one write strobe, ends when its effect is visible
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	// one read strobe, answer taken one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		d = reg_rdata;
	endtask

	// key write with mode context, checks the one-cycle answer
	task automatic key(input logic [7:0] d, input logic sa, input logic to,
		input logic ld, input logic dt, input logic wd);
		stand_alone = sa;
		comm_watchdog_timeout_bits = to;
		wr(ADDR_SOFT_RESET, d);
		`CHK(soft_reset_pulse, 1'b1)
		`CHK(setpoints, dflt)
		`CHK(wdog_enable, wd)
		`CHK(chan_cmd, {ld, dt})
		`CHK(power_on_indicator_bit, 1'b0)
		@(negedge core_clk);
		`CHK({soft_reset_pulse, chan_cmd}, 3'h0)
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		bad_count = 0;
		check_count = 0;
		dflt = {RST_DIM_WIDTH, RST_DIM_WIDTH, RST_ON_TIME, RST_ON_TIME};
		{srst, reg_wr, reg_rd, stand_alone, comm_watchdog_timeout_bits} = 5'h10;
		{reg_addr, reg_wdata, power_on_clear} = 17'h0;
		repeat (20) @(negedge core_clk);
		srst = 1'b0;
		`CHK({wdog_enable, power_on_indicator_bit}, 2'h3)
		// reset values of every mapped offset
		for (int a = 8'h28; a <= 8'h2e; a++)
		begin
			rd(8'(a), rd_val);
			`CHK(rd_val, (a == 8'h2c || a == 8'h2d) ? 8'h07 : 8'h00)
		end
		// ordinary accesses from the table
		for (int i = 0; i < 8; i++)
		begin
			wr(ROWS[i][23:16], ROWS[i][15:8]);
			rd(ROWS[i][23:16], rd_val);
			`CHK(rd_val, ROWS[i][7:0])
		end
		`CHK(setpoints, {10'h3a5, 10'h25a, 6'h3f, 6'h08})
		`CHK({soft_reset_pulse, chan_cmd, wdog_enable}, 4'h1)
		// clear the power-on indicator so a soft reset cannot hide behind it
		@(negedge core_clk);
		power_on_clear = 1'b1;
		@(negedge core_clk);
		power_on_clear = 1'b0;
		`CHK(power_on_indicator_bit, 1'b0)
		key(KEY_WDOG_OFF, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		wr(ADDR_CH1_ON_TIME, 8'h15);
		key(KEY_WDOG_ON, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		key(KEY_WDOG_ON, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		key(KEY_WDOG_OFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		key(KEY_WDOG_ON, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		// write and read in one cycle: the read answers the old value
		@(negedge core_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, ADDR_CH2_ON_TIME, 8'h2a};
		@(negedge core_clk);
		{reg_wr, reg_rd} = 2'b00;
		`CHK(reg_rdata, 8'h07)
		`CHK(setpoints.fallback_ch2_on_time, 6'h2a)
		// second power-on reset in mid-run
		srst = 1'b1;
		@(negedge core_clk);
		srst = 1'b0;
		`CHK({power_on_indicator_bit, wdog_enable}, 2'h3)
		`CHK(setpoints, dflt)
		give_verdict();
	end

	// cut a hang short
	initial
	begin
		#(20 * 2000);
		bad_count++;
		give_verdict();
	end
endmodule
